/* core/emi_core.sv */
// Contract
// [RULE1] In split bank-select mode, addresses below the on-chip boundary go on-chip and the rest off-chip.
// [RULE2] In split bank-select mode, an 8-bit move forms its address from the page byte and the pointer byte and drives all sixteen lines.
// [RULE3] In split bank-select mode, a 16-bit move decides by the data pointer and drives all sixteen lines off-chip.
// [RULE4] In external-only mode every move goes off-chip and on-chip RAM is never touched.
// [RULE5] In external-only mode an 8-bit move ignores the page byte, leaves the upper lines undriven and uses the pointer byte.
// [RULE6] In external-only mode a 16-bit move takes its whole address from the data pointer and drives all sixteen lines.
// [RULE7] Setup, hold, strobe width and latch width are programmable in clock periods, latch width from config bits 1:0.
// [RULE8] An off-chip move lasts the sum of the programmed phases plus four clock cycles.
// [RULE9] The shortest non-multiplexed off-chip move is five cycles with a one-cycle strobe.
// [RULE10] The latch phase adds at least two cycles, so the shortest multiplexed move is seven cycles.
// [RULE11] After reset, setup and hold come up at their largest settings.
// [RULE12] Config bits 4:2 equal to 001, 010 or 011 select the multiplexed bus.
`timescale 1ns/1ps
`default_nettype none

module emi_core
  import emi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Configuration writes
  input wire logic cfg_wr,
  input wire logic [CFG_W-1:0] cfg_wdata,
  input wire logic timing_wr,
  input wire logic [TC_W-1:0] timing_wdata,
  input wire logic page_wr,
  input wire logic [DATA_W-1:0] page_wdata,
  // Configuration readback
  output logic [CFG_W-1:0] emif_config,
  output logic [TC_W-1:0] emif_timing_control,
  output logic [DATA_W-1:0] external_data_ram_page_select,
  // CPU move request
  input wire logic move_req,
  input wire logic move_write,
  input wire logic move_wide,
  input wire logic [ADDR_W-1:0] data_pointer,
  input wire logic [DATA_W-1:0] indirect_pointer,
  input wire logic [DATA_W-1:0] move_wdata,
  // CPU move answer
  output logic move_busy,
  output logic move_done,
  output logic move_offchip,
  output logic [DATA_W-1:0] move_rdata,
  // On-chip RAM port
  output logic onchip_req,
  output logic onchip_we,
  output logic [ADDR_W-1:0] onchip_addr,
  output logic [DATA_W-1:0] onchip_wdata,
  input wire logic [DATA_W-1:0] onchip_rdata,
  // Off-chip bus pins
  output logic [ADDR_W-1:0] addr_out,
  output logic addr_hi_oe,
  output logic addr_lo_oe,
  output logic [DATA_W-1:0] data_out,
  output logic data_oe,
  input wire logic [DATA_W-1:0] data_in,
  output logic rd_n,
  output logic wr_n,
  output logic ale
);

  // ==========================================================================
  // Configuration registers
  logic [CFG_W-1:0] cfg_q, cfg_d;
  logic [TC_W-1:0] tc_q, tc_d;
  logic [DATA_W-1:0] page_q, page_d;

  always_comb
  begin
    cfg_d = cfg_wr ? cfg_wdata : cfg_q;
    tc_d = timing_wr ? timing_wdata : tc_q; // [RULE7]
    page_d = page_wr ? page_wdata : page_q;
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      cfg_q <= CFG_RESET;
      tc_q <= TC_RESET; // [RULE11]
      page_q <= {DATA_W{1'b0}};
    end
    else
    begin
      cfg_q <= cfg_d;
      tc_q <= tc_d;
      page_q <= page_d;
    end
  end

  emi_map_type map_mode;
  logic mux_mode;
  logic [PHASE_W-1:0] len_ale, len_setup, len_strobe, len_hold;

  always_comb
  begin
    map_mode = emi_map_type'(cfg_q[CFG_MAP_LSB +: CFG_MAP_W]);
    mux_mode = !cfg_q[CFG_NOMUX_BIT] && (map_mode != EMI_MAP_ONCHIP); // [RULE12]
    len_ale = PHASE_W'(cfg_q[CFG_ALE_LSB +: CFG_ALE_W]) + PHASE_ONE; // [RULE7] [RULE10]
    len_setup = PHASE_W'(tc_q[TC_SETUP_LSB +: TC_SETUP_W]);
    len_strobe = PHASE_W'(tc_q[TC_STRB_LSB +: TC_STRB_W]) + PHASE_ONE; // [RULE9]
    len_hold = PHASE_W'(tc_q[TC_HOLD_LSB +: TC_HOLD_W]);
  end

  // ==========================================================================
  // Address steering
  logic [ADDR_W-1:0] map_addr;
  logic map_offchip;
  logic map_drive_hi;

  emi_addr_map u_map (
    .map_mode(map_mode),
    .wide(move_wide),
    .data_pointer(data_pointer),
    .indirect_pointer(indirect_pointer),
    .page(page_q),
    .eff_addr(map_addr),
    .offchip(map_offchip),
    .drive_hi(map_drive_hi)
  );

  // ==========================================================================
  // Data input synchroniser
  logic [DATA_W-1:0] din_meta_q, din_sync_q;

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      din_meta_q <= {DATA_W{1'b0}};
      din_sync_q <= {DATA_W{1'b0}};
    end
    else
    begin
      din_meta_q <= data_in;
      din_sync_q <= din_meta_q;
    end
  end

  // ==========================================================================
  // Sequencer
  emi_state_type state_q, state_d;
  logic [ADDR_W-1:0] xa_addr_q, xa_addr_d;
  logic xa_write_q, xa_write_d;
  logic xa_hi_q, xa_hi_d;
  logic xa_mux_q, xa_mux_d;
  logic [DATA_W-1:0] xa_wdata_q, xa_wdata_d;
  logic phase_last;
  logic phase_load;
  logic [PHASE_W-1:0] phase_len;

  emi_phase_timer u_timer (
    .mclk(mclk),
    .srst(srst),
    .load(phase_load),
    .length(phase_len),
    .last(phase_last)
  );

  always_comb
  begin
    state_d = state_q;
    xa_addr_d = xa_addr_q;
    xa_write_d = xa_write_q;
    xa_hi_d = xa_hi_q;
    xa_mux_d = xa_mux_q;
    xa_wdata_d = xa_wdata_q;
    case (state_q)
      EMI_IDLE:
      begin
        if (move_req)
        begin
          xa_addr_d = map_addr;
          xa_write_d = move_write;
          xa_hi_d = map_drive_hi;
          xa_mux_d = mux_mode;
          xa_wdata_d = move_wdata;
          state_d = map_offchip ? EMI_ADDR : EMI_ONCHIP; // [RULE1] [RULE4]
        end
      end
      EMI_ADDR: state_d = xa_mux_q ? EMI_ALE : (len_setup != PHASE_ZERO) ? EMI_SETUP : EMI_STROBE; // [RULE8]
      EMI_ALE: state_d = phase_last ? EMI_ALE_HOLD : EMI_ALE; // [RULE10]
      EMI_ALE_HOLD: state_d = (len_setup != PHASE_ZERO) ? EMI_SETUP : EMI_STROBE;
      EMI_SETUP: state_d = phase_last ? EMI_STROBE : EMI_SETUP;
      EMI_STROBE: state_d = !phase_last ? EMI_STROBE : (len_hold != PHASE_ZERO) ? EMI_HOLD : EMI_CAPTURE;
      EMI_HOLD: state_d = phase_last ? EMI_CAPTURE : EMI_HOLD;
      EMI_CAPTURE: state_d = EMI_RELEASE;
      EMI_RELEASE: state_d = EMI_FINISH;
      EMI_ONCHIP: state_d = EMI_ONWAIT;
      EMI_ONWAIT: state_d = EMI_FINISH;
      default: state_d = EMI_IDLE;
    endcase
  end

  always_comb
  begin
    phase_load = (state_d != state_q);
    case (state_d)
      EMI_ALE: phase_len = len_ale; // [RULE7]
      EMI_SETUP: phase_len = len_setup; // [RULE7]
      EMI_STROBE: phase_len = len_strobe; // [RULE7]
      EMI_HOLD: phase_len = len_hold; // [RULE7]
      default: phase_len = PHASE_ONE;
    endcase
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      state_q <= EMI_IDLE;
      xa_addr_q <= {ADDR_W{1'b0}};
      xa_write_q <= 1'b0;
      xa_hi_q <= 1'b0;
      xa_mux_q <= 1'b0;
      xa_wdata_q <= {DATA_W{1'b0}};
    end
    else
    begin
      state_q <= state_d;
      xa_addr_q <= xa_addr_d;
      xa_write_q <= xa_write_d;
      xa_hi_q <= xa_hi_d;
      xa_mux_q <= xa_mux_d;
      xa_wdata_q <= xa_wdata_d;
    end
  end

  // ==========================================================================
  // Registered outputs
  logic busy_d, done_d, offchip_d;
  logic [DATA_W-1:0] rdata_q, rdata_d;
  logic rd_seen_q, rd_seen_d, rd_take_q, rd_take_d;
  logic oreq_d, owe_d;
  logic [ADDR_W-1:0] aout_d;
  logic ahi_d, alo_d, doe_d, rdn_d, wrn_d, ale_d;
  logic [DATA_W-1:0] dout_d;
  logic busy_q, done_q, offchip_q, oreq_q, owe_q;
  logic [ADDR_W-1:0] aout_q;
  logic ahi_q, alo_q, doe_q, rdn_q, wrn_q, ale_q;
  logic [DATA_W-1:0] dout_q;
  logic bus_active, latch_phase;

  always_comb
  begin
    bus_active = state_d inside {EMI_ADDR, EMI_ALE, EMI_ALE_HOLD, EMI_SETUP, EMI_STROBE, EMI_HOLD, EMI_CAPTURE};
    latch_phase = (state_d == EMI_ADDR) || (state_d == EMI_ALE) || (state_d == EMI_ALE_HOLD);
    busy_d = (state_d != EMI_IDLE);
    done_d = (state_d == EMI_FINISH); // [RULE8]
    offchip_d = (state_q == EMI_IDLE) ? (move_req && map_offchip) : offchip_q;
    // Take pin data two cycles after the last strobe cycle, behind the synchroniser
    rd_seen_d = (state_q == EMI_STROBE) && phase_last && !xa_write_q;
    rd_take_d = rd_seen_q;
    rdata_d = rd_take_q ? din_sync_q : ((state_q == EMI_ONWAIT) && !xa_write_q) ? onchip_rdata : rdata_q;
    oreq_d = (state_d == EMI_ONCHIP);
    owe_d = (state_d == EMI_ONCHIP) && xa_write_d;
    aout_d = bus_active ? xa_addr_d : aout_q;
    ahi_d = bus_active && xa_hi_d; // [RULE2] [RULE5] [RULE6]
    alo_d = bus_active && !xa_mux_d;
    ale_d = (state_d == EMI_ALE); // [RULE10]
    rdn_d = !((state_d == EMI_STROBE) && !xa_write_d);
    wrn_d = !((state_d == EMI_STROBE) && xa_write_d);
    dout_d = (xa_mux_d && latch_phase) ? xa_addr_d[DATA_W-1:0] : xa_wdata_d; // [RULE12]
    doe_d = (xa_mux_d && latch_phase) || (bus_active && xa_write_d && !latch_phase && (state_d != EMI_CAPTURE));
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      busy_q <= 1'b0;
      done_q <= 1'b0;
      offchip_q <= 1'b0;
      rdata_q <= {DATA_W{1'b0}};
      rd_seen_q <= 1'b0;
      rd_take_q <= 1'b0;
      oreq_q <= 1'b0;
      owe_q <= 1'b0;
      aout_q <= {ADDR_W{1'b0}};
      ahi_q <= 1'b0;
      alo_q <= 1'b0;
      dout_q <= {DATA_W{1'b0}};
      doe_q <= 1'b0;
      rdn_q <= 1'b1;
      wrn_q <= 1'b1;
      ale_q <= 1'b0;
    end
    else
    begin
      busy_q <= busy_d;
      done_q <= done_d;
      offchip_q <= offchip_d;
      rdata_q <= rdata_d;
      rd_seen_q <= rd_seen_d;
      rd_take_q <= rd_take_d;
      oreq_q <= oreq_d;
      owe_q <= owe_d;
      aout_q <= aout_d;
      ahi_q <= ahi_d;
      alo_q <= alo_d;
      dout_q <= dout_d;
      doe_q <= doe_d;
      rdn_q <= rdn_d;
      wrn_q <= wrn_d;
      ale_q <= ale_d;
    end
  end

  assign emif_config = cfg_q;
  assign emif_timing_control = tc_q;
  assign external_data_ram_page_select = page_q;
  assign move_busy = busy_q;
  assign move_done = done_q;
  assign move_offchip = offchip_q;
  assign move_rdata = rdata_q;
  assign onchip_req = oreq_q;
  assign onchip_we = owe_q;
  assign onchip_addr = xa_addr_q;
  assign onchip_wdata = xa_wdata_q;
  assign addr_out = aout_q;
  assign addr_hi_oe = ahi_q;
  assign addr_lo_oe = alo_q;
  assign data_out = dout_q;
  assign data_oe = doe_q;
  assign rd_n = rdn_q;
  assign wr_n = wrn_q;
  assign ale = ale_q;

endmodule // emi_core

`default_nettype wire

/* core/emi_pkg.sv */
package emi_pkg;

  // ==========================================================================
  // Configuration fields
  localparam int unsigned CFG_W = 5;
  localparam int unsigned CFG_ALE_LSB = 0;
  localparam int unsigned CFG_ALE_W = 2;
  localparam int unsigned CFG_MAP_LSB = 2;
  localparam int unsigned CFG_MAP_W = 2;
  localparam int unsigned CFG_NOMUX_BIT = 4;
  localparam logic [CFG_W-1:0] CFG_RESET = 5'h00;

  // ==========================================================================
  // Timing control fields
  localparam int unsigned TC_W = 8;
  localparam int unsigned TC_HOLD_LSB = 0;
  localparam int unsigned TC_HOLD_W = 2;
  localparam int unsigned TC_STRB_LSB = 2;
  localparam int unsigned TC_STRB_W = 4;
  localparam int unsigned TC_SETUP_LSB = 6;
  localparam int unsigned TC_SETUP_W = 2;
  localparam logic [TC_W-1:0] TC_RESET = 8'hFF;

  // ==========================================================================
  // Mapping modes
  typedef enum logic [1:0] {
    EMI_MAP_ONCHIP = 2'h0,
    EMI_MAP_SPLIT = 2'h1,
    EMI_MAP_SPLIT_BANK = 2'h2,
    EMI_MAP_EXT_ONLY = 2'h3
  } emi_map_type;

  // ==========================================================================
  // Sizes and fixed figures
  localparam int unsigned ADDR_W = 16;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned PHASE_W = 4;
  localparam logic [ADDR_W-1:0] ONCHIP_BOUNDARY = 16'h0800;
  localparam logic [PHASE_W-1:0] PHASE_ONE = 4'h1;
  localparam logic [PHASE_W-1:0] PHASE_ZERO = 4'h0;

  // ==========================================================================
  // Sequencer states, Gray from EMI_IDLE to EMI_FINISH along the multiplexed off-chip path with setup and hold
  typedef enum logic [3:0] {
    EMI_IDLE = 4'h0,
    EMI_ADDR = 4'h1,
    EMI_ALE = 4'h3,
    EMI_ALE_HOLD = 4'h2,
    EMI_SETUP = 4'h6,
    EMI_STROBE = 4'h7,
    EMI_HOLD = 4'h5,
    EMI_CAPTURE = 4'h4,
    EMI_RELEASE = 4'hC,
    EMI_FINISH = 4'hD,
    EMI_ONCHIP = 4'h8,
    EMI_ONWAIT = 4'h9
  } emi_state_type;

endpackage

/* core/emi_addr_map.sv */
`timescale 1ns/1ps
`default_nettype none

module emi_addr_map
  import emi_pkg::*;
(
  // Mode and request shape
  input wire emi_map_type map_mode,
  input wire logic wide,
  // Address sources
  input wire logic [ADDR_W-1:0] data_pointer,
  input wire logic [DATA_W-1:0] indirect_pointer,
  input wire logic [DATA_W-1:0] page,
  // Decision
  output logic [ADDR_W-1:0] eff_addr,
  output logic offchip,
  output logic drive_hi
);

  always_comb
  begin
    eff_addr = wide ? data_pointer : {page, indirect_pointer};
    offchip = 1'b0;
    drive_hi = 1'b0;
    case (map_mode)
      EMI_MAP_SPLIT_BANK:
      begin
        offchip = (eff_addr >= ONCHIP_BOUNDARY); // [RULE1] [RULE2] [RULE3]
        drive_hi = 1'b1; // [RULE2] [RULE3]
      end
      EMI_MAP_EXT_ONLY:
      begin
        offchip = 1'b1; // [RULE4]
        drive_hi = wide; // [RULE5] [RULE6]
        if (!wide)
        begin
          eff_addr = {{DATA_W{1'b0}}, indirect_pointer}; // [RULE5]
        end
      end
      EMI_MAP_SPLIT:
      begin
        offchip = (eff_addr >= ONCHIP_BOUNDARY);
        drive_hi = wide;
      end
      default:
      begin
        offchip = 1'b0;
      end
    endcase
  end

endmodule // emi_addr_map

`default_nettype wire

/* core/emi_phase_timer.sv */
`timescale 1ns/1ps
`default_nettype none

module emi_phase_timer
  import emi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Control
  input wire logic load,
  input wire logic [PHASE_W-1:0] length,
  // Status
  output logic last
);

  logic [PHASE_W-1:0] count_q;
  logic [PHASE_W-1:0] count_d;

  always_comb
  begin
    count_d = count_q;
    if (load)
    begin
      count_d = length - PHASE_ONE;
    end
    else if (count_q != PHASE_ZERO)
    begin
      count_d = count_q - PHASE_ONE;
    end
  end

  always_ff @(posedge mclk)
  begin
    if (srst)
    begin
      count_q <= PHASE_ZERO;
    end
    else
    begin
      count_q <= count_d;
    end
  end

  assign last = (count_q == PHASE_ZERO);

endmodule // emi_phase_timer

`default_nettype wire

/* verification/emi_core_props.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Timing and address steering checks
module emi_core_props
  import emi_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic srst,
  // Configuration readback
  input wire logic [CFG_W-1:0] emif_config,
  input wire logic [TC_W-1:0] emif_timing_control,
  input wire logic [DATA_W-1:0] external_data_ram_page_select,
  // Move request and answer
  input wire logic move_req,
  input wire logic move_wide,
  input wire logic [ADDR_W-1:0] data_pointer,
  input wire logic [DATA_W-1:0] indirect_pointer,
  input wire logic move_busy,
  input wire logic move_done,
  input wire logic move_offchip,
  input wire logic onchip_req,
  // Bus pins
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic addr_hi_oe,
  input wire logic addr_lo_oe,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale
);
  logic [5:0] busy_q, busy_d, n_exp;
  logic [4:0] strb_q, strb_d;
  logic [2:0] ale_q, ale_d;

  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // ==========================================
  // Phase counters
  always_comb
  begin
    busy_d = move_busy ? busy_q + 6'h01 : 6'h00;
    strb_d = (!rd_n || !wr_n) ? strb_q + 5'h01 : 5'h00;
    ale_d = ale ? ale_q + 3'h1 : 3'h0;
  end

  always_ff @(posedge mclk)
  begin
    busy_q <= srst ? 6'h00 : busy_d;
    strb_q <= srst ? 5'h00 : strb_d;
    ale_q <= srst ? 3'h0 : ale_d;
  end

  assign n_exp = 6'h05 + 6'(emif_timing_control[7:6]) + 6'(emif_timing_control[5:2])
    + 6'(emif_timing_control[1:0]) + (emif_config[4] ? 6'h00 : 6'(emif_config[1:0]) + 6'h02);

  // ==========================================
  // Request shapes
  sequence s_narrow_ext;
    move_req && !move_busy && !move_wide && emif_config[3:2] == 2'h3;
  endsequence
  sequence s_wide_ext;
    move_req && !move_busy && move_wide && emif_config[3:2] == 2'h3;
  endsequence
  sequence s_narrow_bank;
    move_req && !move_busy && !move_wide && emif_config[3:2] == 2'h2;
  endsequence
  sequence s_wide_bank;
    move_req && !move_busy && move_wide && emif_config[3:2] == 2'h2;
  endsequence

  // ==========================================
  // Assertions
  AST_DURATION: assert property (move_done && move_offchip |-> busy_q + 6'h01 == n_exp)
    else $error("off-chip move length wrong");
  AST_MIN_NONMUX: assert property (move_done && move_offchip && emif_config[4] |-> busy_q >= 6'h04)
    else $error("non-multiplexed move too short");
  AST_MIN_MUX: assert property (move_done && move_offchip && !emif_config[4] |-> busy_q >= 6'h06)
    else $error("multiplexed move too short");
  AST_STROBE_W: assert property ($rose(rd_n && wr_n) |-> strb_q == 5'(emif_timing_control[5:2]) + 5'h01)
    else $error("strobe width wrong");
  AST_ALE_W: assert property ($fell(ale) |-> ale_q == 3'(emif_config[1:0]) + 3'h1)
    else $error("latch pulse width wrong");
  AST_RESET_TIMING: assert property ($fell(srst) |-> emif_timing_control[7:6] == 2'h3
    && emif_timing_control[1:0] == 2'h3) else $error("setup or hold not maximal after reset");
  AST_EXT_NO_ONCHIP: assert property (emif_config[3:2] == 2'h3 |-> !onchip_req)
    else $error("on-chip access in external-only mode");
  AST_MUX_PINS: assert property (emif_config[4] ? !ale : !addr_lo_oe)
    else $error("bus multiplexing does not follow config");
  AST_NARROW_EXT: assert property (s_narrow_ext |=> !addr_hi_oe && move_offchip
    && (emif_config[4] ? addr_out[7:0] : data_out) == $past(indirect_pointer)) else $error("narrow external address wrong");
  AST_WIDE_EXT: assert property (s_wide_ext |=> addr_hi_oe && move_offchip
    && addr_out[15:8] == $past(data_pointer[15:8])) else $error("wide external address wrong");
  AST_BANK_WIDE: assert property (s_wide_bank |=> move_offchip == ($past(data_pointer) >= ONCHIP_BOUNDARY)
    && (!move_offchip || addr_hi_oe)) else $error("wide bank-select decision wrong");
  AST_BANK_NARROW: assert property (s_narrow_bank |=>
    move_offchip == ({$past(external_data_ram_page_select), $past(indirect_pointer)} >= ONCHIP_BOUNDARY)
    && (!move_offchip || addr_hi_oe && addr_out[15:8] == $past(external_data_ram_page_select))) else $error("narrow bank-select wrong");
endmodule // emi_core_props

bind emi_core emi_core_props u_emi_core_props (.*);

`default_nettype wire

/* verification/emi_sram_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Off-chip parallel memory
module emi_sram_model
  import emi_pkg::*;
#(
  parameter logic [7:0] PORT_HI = 8'h00
)
(
  // Clock
  input wire logic mclk,
  // Bus pins
  input wire logic [ADDR_W-1:0] addr_out,
  input wire logic addr_hi_oe,
  input wire logic addr_lo_oe,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic data_oe,
  input wire logic rd_n,
  input wire logic wr_n,
  input wire logic ale,
  output logic [DATA_W-1:0] data_in
);
  logic [7:0] mem [0:65535];
  logic [7:0] lat_lo = 8'h00;
  logic [7:0] last = 8'h00;
  logic rd_q = 1'b0;
  logic drive;
  logic [15:0] cur;

  // Undriven upper lines follow the port state
  assign cur = {addr_hi_oe ? addr_out[15:8] : PORT_HI, addr_lo_oe ? addr_out[7:0] : lat_lo};
  assign drive = !rd_n || rd_q;

  always @(posedge mclk)
  begin
    if (ale)
      lat_lo <= data_out;
    if (!wr_n && data_oe)
      mem[cur] <= data_out;
    if (drive)
      last <= data_in;
    rd_q <= !rd_n;
  end

  // Released bus shows the inverse of the last value
  always @*
    data_in = drive ? mem[cur] : ~last;
endmodule // emi_sram_model

`default_nettype wire

/* verification/test_emi_core.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Testbench
module test_emi_core
  import emi_pkg::*;
;
  logic mclk, srst, cfg_wr, timing_wr, page_wr, move_req, move_write, move_wide;
  logic [4:0] cfg_wdata, emif_config;
  logic [7:0] timing_wdata, page_wdata, emif_timing_control, external_data_ram_page_select, indirect_pointer;
  logic [7:0] move_wdata, move_rdata, onchip_rdata, onchip_wdata, data_out, data_in;
  logic [15:0] data_pointer, onchip_addr, addr_out;
  logic move_busy, move_done, move_offchip, onchip_req, onchip_we;
  logic addr_hi_oe, addr_lo_oe, data_oe, rd_n, wr_n, ale;
  logic [7:0] oram [0:2047];
  int n_mismatch = 0;
  int n_compared = 0;

  emi_core u_emi_core (.*);
  emi_sram_model u_emi_sram_model (.*);

  always #50 mclk = ~mclk;

  // On-chip RAM, one cycle read latency
  always @(posedge mclk)
  begin
    if (onchip_req && onchip_we)
      oram[onchip_addr[10:0]] <= onchip_wdata;
    if (onchip_req)
      onchip_rdata <= oram[onchip_addr[10:0]];
  end

  // ==========================================
  // Helpers
  task automatic results();
    if (n_mismatch == 0 && n_compared > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  task automatic chk(input logic [15:0] got, exp);
    n_compared++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask

  function automatic int nexp(logic [4:0] c, logic [7:0] t);
    return 5 + t[7:6] + t[5:2] + t[1:0] + (c[4] ? 0 : c[1:0] + 2);
  endfunction

  task automatic cfg_set(input logic [4:0] c, input logic [7:0] t, p);
    @(negedge mclk);
    {cfg_wr, timing_wr, page_wr} = 3'h7;
    cfg_wdata = c;
    timing_wdata = t;
    page_wdata = p;
    @(negedge mclk);
    {cfg_wr, timing_wr, page_wr} = 3'h0;
    chk({emif_config, emif_timing_control}, {c, t});
  endtask

  task automatic move(input logic w, wd, input logic [15:0] dp, input logic [7:0] ip, d,
    output logic [7:0] r, output int n);
    @(negedge mclk);
    move_req = 1'b1;
    move_write = w;
    move_wide = wd;
    data_pointer = dp;
    indirect_pointer = ip;
    move_wdata = d;
    n = 0;
    repeat (100)
    begin
      @(negedge mclk);
      move_req = 1'b0;
      n++;
      if (move_done === 1'b1)
        break;
    end
    chk(16'(move_done), 16'h0001);
    if (move_done !== 1'b1)
      results();
    r = move_rdata;
  endtask

  task automatic wr_rd(input logic [4:0] c, input logic [7:0] t, p, input logic wd,
    input logic [15:0] dp, input logic [7:0] ip, d, input logic off);
    int n;
    int e;
    logic [7:0] r;
    e = off ? nexp(c, t) : 3;
    cfg_set(c, t, p);
    move(1'b1, wd, dp, ip, d, r, n);
    chk(16'(n), 16'(e));
    chk(16'(move_offchip), 16'(off));
    move(1'b0, wd, dp, ip, 8'h00, r, n);
    chk(16'(n), 16'(e));
    chk(16'(r), 16'(d));
  endtask

  // ==========================================
  // Scenarios
  task automatic sc_reset();
    chk(16'(emif_timing_control), 16'h00FF);
    chk(16'({emif_config, external_data_ram_page_select, rd_n, wr_n}), 16'h0003);
  endtask

  task automatic sc_nonmux();
    logic [7:0] t [4] = '{8'h00, 8'hFF, 8'h94, 8'h4B};
    for (int i = 0; i < 4; i++)
      wr_rd(5'h18, t[i], 8'h00, 1'b1, 16'h1200 + 16'(i), 8'h00, 8'hC0 + 8'(i), 1'b1);
  endtask

  task automatic sc_mux();
    for (int i = 0; i < 4; i++)
      wr_rd({1'b0, 2'(i % 3 + 1), 2'(i)}, {2'(i), 6'h00}, 8'h00, 1'b1, 16'h2300 + 16'(i), 8'h00,
        8'h50 + 8'(i), 1'b1);
  endtask

  task automatic sc_bank();
    logic [15:0] a [6] = '{16'h07FF, 16'h0800, 16'hA53C, 16'h07FF, 16'h0800, 16'h0001};
    for (int i = 0; i < 6; i++)
      wr_rd(5'h18, 8'h00, a[i][15:8], i > 2, a[i], a[i][7:0], 8'h10 + 8'(i), a[i] >= ONCHIP_BOUNDARY);
  endtask

  task automatic sc_ext();
    int n;
    logic [7:0] r;
    wr_rd(5'h1C, 8'h00, 8'h05, 1'b0, 16'hFFFF, 8'h10, 8'h77, 1'b1);
    move(1'b0, 1'b1, 16'h0010, 8'h00, 8'h00, r, n);
    chk(16'(r), 16'h0077);
    wr_rd(5'h1C, 8'h00, 8'h00, 1'b1, 16'h07FF, 8'h00, 8'h99, 1'b1);
    cfg_set(5'h18, 8'h00, 8'h00);
    move(1'b0, 1'b1, 16'h07FF, 8'h00, 8'h00, r, n);
    chk(16'(r), 16'h0013);
  endtask

  initial
  begin
    {mclk, cfg_wr, timing_wr, page_wr, move_req, move_write, move_wide} = 7'h00;
    {cfg_wdata, timing_wdata, page_wdata, indirect_pointer, move_wdata} = 37'h0;
    data_pointer = 16'h0000;
    onchip_rdata = 8'h00;
    srst = 1'b1;
    repeat (4) @(negedge mclk);
    srst = 1'b0;
    sc_reset();
    sc_nonmux();
    sc_mux();
    sc_bank();
    sc_ext();
    results();
  end
endmodule // test_emi_core

`default_nettype wire
